/* hw/ptch_cmd.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ptch_map.svh"

// Operation
// R01 - Sentence opcode takes index plus two-byte argument.
// R02 - Sentence end sets done flag and request.
// R03 - No vocabulary: play commands report invalid state.
// R04 - Week opcode loads clock from two bytes.
// R05 - Low bits weekday 1-7, next hour 0-23.
// R06 - Host puts minute above hour, top ones.
// R07 - Bad week field sets bad argument error.
// R08 - Label opcode writes current message tag.
// R09 - Label write only clears zero bits.
// R10 - No message: invalid state, tag unchanged.
// R11 - Host reads, modifies, then writes the tag.
// R12 - Word opcode takes one-byte word index.
// R13 - Word end sets done flag and request.
// R14 - Bad or control word index: argument error.
// R15 - Stop opcode ends playback, back to idle.
// R16 - Every received byte is echoed in order.
// R17 - Rejected command: error only, no action.
module ptch_cmd
  import ptch_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output var  logic        tx_valid,
  output var  logic [7:0]  tx_data,
  output var  logic        play_start,
  output var  logic        play_sentence,
  output var  logic [7:0]  play_index,
  output var  logic [15:0] play_arg,
  output var  logic        play_stop,
  input  wire logic        play_done,
  output var  logic        host_attention_request,
  output var  logic        irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ptch_state_t         state_r;     // Interpreter state.
  logic [1:0]          cnt_r;       // Parameter bytes still due.
  logic [7:0]          op_r;        // Opcode being collected.
  logic [7:0]          p0_r;        // Previous parameter byte.
  logic [7:0]          p1_r;        // Parameter byte before p0_r.
  logic [31:0]         cfg_r;       // Vocabulary and message setup.
  logic [`PTCH_ST_W-1:0] mask_r;    // Interrupt mask.
  logic [`PTCH_ST_W-1:0] stat;      // Sticky status bits.
  logic [`PTCH_ST_W-1:0] st_set;    // Status set pulses.
  logic [`PTCH_ST_W-1:0] st_clr;    // Status clear pulses.
  logic [15:0]         tag_r;       // Current message tag.
  logic [15:0]         clock_r;     // Week clock word.
  logic                aw_hold_r;   // Write address captured.
  logic [7:0]          aw_addr_r;   // Captured write address.
  logic                w_hold_r;    // Write data captured.
  logic [31:0]         w_data_r;    // Captured write data.
  logic [3:0]          w_strb_r;    // Captured byte strobes.
  logic                wr_go;       // Register write happens now.
  logic                last;        // Final parameter byte arrives.
  logic                is_sent;     // Opcode decodes.
  logic                is_word;
  logic                is_week;
  logic                is_label;
  logic [15:0]         word16;      // Two-byte parameter, high first.
  logic                vocab;       // A vocabulary is selected.
  logic                msg;         // A current message exists.
  logic                week_ok;     // Week word is in range.
  logic                word_ok;     // Word index names a word.
  logic                start;       // Playback begins.
  logic                stop_hit;    // Stop opcode during playback.

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign last     = rx_valid && state_r == st_args && cnt_r == 2'h1;
  assign is_sent  = op_r == `PTCH_OP_SENT;   // R01
  assign is_word  = op_r == `PTCH_OP_WORD;   // R12
  assign is_week  = op_r == `PTCH_OP_WEEK;   // R04
  assign is_label = op_r == `PTCH_OP_LABEL;  // R08
  assign word16   = {p0_r, rx_data};
  assign vocab    = cfg_r[`PTCH_CFG_VOCAB];
  assign msg      = cfg_r[`PTCH_CFG_MSG];
  assign stop_hit = rx_valid && state_r == st_play
                    && rx_data == `PTCH_OP_STOP;

  // Range checks on the week word fields.
  assign week_ok = word16[`PTCH_WK_DAY] >= `PTCH_DAY_MIN   // R05
                && word16[`PTCH_WK_DAY] <= `PTCH_DAY_MAX
                && word16[`PTCH_WK_HOUR] <= `PTCH_HOUR_MAX
                && word16[`PTCH_WK_MIN] <= `PTCH_MIN_MAX   // R06
                && word16[`PTCH_WK_TOP] == `PTCH_TOP_VAL;

  // Control and option codes sit at or above the configured base.
  assign word_ok = rx_data <= cfg_r[`PTCH_CFG_LAST]
                && rx_data < cfg_r[`PTCH_CFG_CTRL];        // R14

  // Playback starts only for a fully valid command.
  assign start = last && vocab && (is_sent || (is_word && word_ok)); // R17

  // Events that set the sticky status bits.
  always_comb
  begin
    st_set = '0;
    st_set[`PTCH_ST_DONE]  = play_done && state_r == st_play
                             && !stop_hit;                 // R02 R13
    st_set[`PTCH_ST_PARAM] = last && ((is_week && !week_ok)  // R07
                             || (is_word && vocab && !word_ok)); // R14
    st_set[`PTCH_ST_INVAL] = last && (((is_sent || is_word) && !vocab)
                             || (is_label && !msg));       // R03 R10
  end

  // ****************************************************************
  // Interpreter state machine
  // ****************************************************************
  // Collects opcode and parameters, then runs or rejects the command.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= st_idle;
      cnt_r   <= '0;
      op_r    <= '0;
      p0_r    <= '0;
      p1_r    <= '0;
    end
    else
    begin
      unique case (state_r)
        st_idle:
        begin
          if (rx_valid)
          begin
            op_r    <= rx_data;
            state_r <= st_args;
            // Unknown opcodes and a stop while idle are only echoed.
            unique case (rx_data)
              `PTCH_OP_SENT:  cnt_r <= `PTCH_N_SENT;  // R01
              `PTCH_OP_WORD:  cnt_r <= `PTCH_N_WORD;  // R12
              `PTCH_OP_WEEK:  cnt_r <= `PTCH_N_WEEK;  // R04
              `PTCH_OP_LABEL: cnt_r <= `PTCH_N_LABEL; // R08
              default:        state_r <= st_idle;
            endcase
          end
        end
        st_args:
        begin
          if (rx_valid)
          begin
            cnt_r <= cnt_r - 2'h1;
            // Shift bytes in so p0 always holds the one before last.
            p0_r  <= rx_data;
            p1_r  <= p0_r;
            if (cnt_r == 2'h1)
            begin
              state_r <= start ? st_play : st_idle;
            end
          end
        end
        st_play:
        begin
          // A stop or the end of playback returns to idle.
          if (stop_hit || play_done)
          begin
            state_r <= st_idle;  // R15
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Playback control
  // ****************************************************************
  // Launches the playback engine and forwards a stop.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      play_start    <= 1'b0;
      play_stop     <= 1'b0;
      play_sentence <= 1'b0;
      play_index    <= '0;
      play_arg      <= '0;
    end
    else
    begin
      play_start <= start;
      play_stop  <= stop_hit;  // R15
      if (start)
      begin
        play_sentence <= is_sent;
        // Sentence: index came first, argument is the last two bytes.
        play_index    <= is_sent ? p1_r : rx_data;  // R01 R12
        play_arg      <= is_sent ? word16 : 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Week clock and message tag
  // ****************************************************************
  // Loads the week clock only from a valid word.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      clock_r <= '0;
    end
    else if (last && is_week && week_ok)
    begin
      clock_r <= word16;  // R04
    end
  end

  // Software sets tag bits on message creation; commands only clear.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tag_r <= '0;
    end
    else if (last && is_label && msg)
    begin
      tag_r <= tag_r & word16;  // R09
    end
    else if (wr_go && aw_addr_r == `PTCH_OFF_TAG)
    begin
      if (w_strb_r[0])
        tag_r[7:0] <= w_data_r[7:0];
      if (w_strb_r[1])
        tag_r[15:8] <= w_data_r[15:8];
    end
  end

  // ****************************************************************
  // Byte echo
  // ****************************************************************
  // Every received byte goes back one cycle later, in order.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_valid <= 1'b0;
      tx_data  <= '0;
    end
    else
    begin
      tx_valid <= rx_valid;  // R16
      tx_data  <= rx_data;
    end
  end

  // ****************************************************************
  // Status, mask and interrupt
  // ****************************************************************
  assign st_clr = (wr_go && aw_addr_r == `PTCH_OFF_STAT && w_strb_r[0])
                  ? w_data_r[`PTCH_ST_W-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `PTCH_ST_W; gi++)
    begin : g_stat
      ptch_sticky u_bit
      (
        .clock (clock),
        .rstn  (rstn),
        .set   (st_set[gi]),
        .clr   (st_clr[gi]),
        .q     (stat[gi])
      );
    end
  endgenerate

  assign host_attention_request = stat[`PTCH_ST_DONE];  // R02 R13
  assign irq = |(stat & mask_r);

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_go         = aw_hold_r && w_hold_r && !s_axi_bvalid;

  // Captures address and data in either order, then answers.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_hold_r    <= 1'b0;
      aw_addr_r    <= '0;
      w_hold_r     <= 1'b0;
      w_data_r     <= '0;
      w_strb_r     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PTCH_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r <= `PTCH_OFF_STATE
                         && aw_addr_r[1:0] == 2'h0)
                        ? `PTCH_RESP_OK : `PTCH_RESP_ERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable configuration and mask registers.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_r  <= `PTCH_CFG_RST;
      mask_r <= '0;
    end
    else if (wr_go)
    begin
      for (int b = 0; b < 4; b++)
        if (w_strb_r[b] && aw_addr_r == `PTCH_OFF_CFG)
          cfg_r[8*b +: 8] <= w_data_r[8*b +: 8];
      if (w_strb_r[0] && aw_addr_r == `PTCH_OFF_MASK)
        mask_r <= w_data_r[`PTCH_ST_W-1:0];
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  // Answers one cycle after the address is taken.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `PTCH_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `PTCH_RESP_OK;
      unique case (s_axi_araddr)
        `PTCH_OFF_CFG:   s_axi_rdata <= cfg_r;
        `PTCH_OFF_STAT:  s_axi_rdata <= {29'h0, stat};
        `PTCH_OFF_MASK:  s_axi_rdata <= {29'h0, mask_r};
        `PTCH_OFF_TAG:   s_axi_rdata <= {16'h0, tag_r};
        `PTCH_OFF_CLOCK: s_axi_rdata <= {16'h0, clock_r};
        `PTCH_OFF_STATE: s_axi_rdata <= {30'h0, state_r};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `PTCH_RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_done;
    @(posedge clock) disable iff (!rstn)
    (state_r == st_play && play_done && !stop_hit)
    |=> host_attention_request && state_r == st_idle;
  endproperty
  a_done: assert property (p_done) else $error("done not flagged"); // R02

  property p_inval;
    @(posedge clock) disable iff (!rstn)
    (last && (is_sent || is_word) && !vocab)
    |=> stat[`PTCH_ST_INVAL] && !play_start;
  endproperty
  a_inval: assert property (p_inval) else $error("no invalid error"); // R03

  property p_week;
    @(posedge clock) disable iff (!rstn)
    (last && is_week && week_ok) |=> clock_r == $past(word16);
  endproperty
  a_week: assert property (p_week) else $error("clock not loaded"); // R04

  property p_badweek;
    @(posedge clock) disable iff (!rstn)
    (last && is_week && !week_ok)
    |=> stat[`PTCH_ST_PARAM] && $stable(clock_r);
  endproperty
  a_badweek: assert property (p_badweek) else $error("bad week kept"); // R07

  property p_label;
    @(posedge clock) disable iff (!rstn)
    (last && is_label && msg) |=> tag_r == ($past(tag_r) & $past(word16));
  endproperty
  a_label: assert property (p_label) else $error("tag not cleared"); // R09

  property p_nomsg;
    @(posedge clock) disable iff (!rstn)
    (last && is_label && !msg && !wr_go)
    |=> stat[`PTCH_ST_INVAL] && $stable(tag_r);
  endproperty
  a_nomsg: assert property (p_nomsg) else $error("tag changed"); // R10

  property p_badword;
    @(posedge clock) disable iff (!rstn)
    (last && is_word && vocab && !word_ok)
    |=> stat[`PTCH_ST_PARAM] && !play_start && state_r == st_idle;
  endproperty
  a_badword: assert property (p_badword) else $error("bad word ran"); // R14

  property p_stop;
    @(posedge clock) disable iff (!rstn)
    stop_hit |=> play_stop && state_r == st_idle ##1 !play_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored"); // R15

  property p_echo;
    @(posedge clock) disable iff (!rstn)
    rx_valid |=> tx_valid && tx_data == $past(rx_data);
  endproperty
  a_echo: assert property (p_echo) else $error("echo lost"); // R16

  c_play: cover property (@(posedge clock) disable iff (!rstn)
    play_start ##[1:20] host_attention_request);
  c_week: cover property (@(posedge clock) disable iff (!rstn)
    last && is_week && week_ok);
  c_stop: cover property (@(posedge clock) disable iff (!rstn) stop_hit);

endmodule

`default_nettype wire

/* hw/ptch_sticky.sv */
`timescale 1ns/1ns
`default_nettype none

// Sticky event bit; a set in the same cycle as a clear wins.
module ptch_sticky
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic set,
  input  wire logic clr,
  output var  logic q
);

  // Holds the flag until software writes a one to clear it.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= 1'b0;
    end
    else if (set)
    begin
      q <= 1'b1;
    end
    else if (clr)
    begin
      q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* shared/ptch_map.svh */
`ifndef PTCH_MAP_SVH
`define PTCH_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PTCH_OFF_CFG    8'h00
`define PTCH_OFF_STAT   8'h04
`define PTCH_OFF_MASK   8'h08
`define PTCH_OFF_TAG    8'h0C
`define PTCH_OFF_CLOCK  8'h10
`define PTCH_OFF_STATE  8'h14

// ****************************************************************
// Configuration fields
// ****************************************************************
`define PTCH_CFG_VOCAB  0
`define PTCH_CFG_MSG    1
`define PTCH_CFG_LAST   15:8
`define PTCH_CFG_CTRL   23:16
`define PTCH_CFG_RST    32'h00FF_FF00

// ****************************************************************
// Status bits, shared by the mask register
// ****************************************************************
`define PTCH_ST_DONE    0
`define PTCH_ST_PARAM   1
`define PTCH_ST_INVAL   2
`define PTCH_ST_W       3

// ****************************************************************
// Opcodes and parameter byte counts
// ****************************************************************
`define PTCH_OP_STOP    8'h00
`define PTCH_OP_SENT    8'h1E
`define PTCH_OP_WEEK    8'h0F
`define PTCH_OP_LABEL   8'h05
`define PTCH_OP_WORD    8'h07
`define PTCH_N_SENT     2'h3
`define PTCH_N_WEEK     2'h2
`define PTCH_N_LABEL    2'h2
`define PTCH_N_WORD     2'h1

// ****************************************************************
// Week clock word fields and limits
// ****************************************************************
`define PTCH_WK_DAY     2:0
`define PTCH_WK_HOUR    7:3
`define PTCH_WK_MIN     13:8
`define PTCH_WK_TOP     15:14
`define PTCH_DAY_MIN    3'h1
`define PTCH_DAY_MAX    3'h7
`define PTCH_HOUR_MAX   5'h17
`define PTCH_MIN_MAX    6'h3B
`define PTCH_TOP_VAL    2'h3

// ****************************************************************
// Bus responses
// ****************************************************************
`define PTCH_RESP_OK    2'h0
`define PTCH_RESP_ERR   2'h2

`endif

/* shared/ptch_pkg.sv */
`default_nettype none

package ptch_pkg;

  // Command interpreter states.
  typedef enum logic [1:0]
  {
    st_idle,
    st_args,
    st_play
  } ptch_state_t;

endpackage

`default_nettype wire

/* tb/ptch_cmd_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ptch_map.svh"

// ********************
// Signals and parts
// ********************
module ptch_cmd_tb;
  logic        clock, rstn;                // Clock and reset.
  logic        awv, awr, wv, wrd, bv, brd; // Write channels.
  logic        arv, ard, rv, rrd;          // Read channels.
  logic [7:0]  awa, ara;                   // Byte addresses.
  logic [31:0] wd, rdat;                   // Bus data.
  logic [1:0]  bresp, rresp, rsp;          // Responses.
  logic        rxv, txv, ps, psen, pstop, pdone, att, irq;
  logic [7:0]  rxd, txd, pidx;             // Bytes and index.
  logic [15:0] parg;                       // Sentence argument.
  int          n_fail, checked;            // Tallies.

  ptch_cmd dut_u
  (
    .clock(clock), .rstn(rstn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(ard),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .rx_valid(rxv),
    .rx_data(rxd), .tx_valid(txv), .tx_data(txd), .play_start(ps),
    .play_sentence(psen), .play_index(pidx), .play_arg(parg),
    .play_stop(pstop), .play_done(pdone),
    .host_attention_request(att), .irq(irq)
  );

  ptch_host host_u
  (
    .clock(clock), .rx_valid(rxv), .rx_data(rxd),
    .tx_valid(txv), .tx_data(txd)
  );

  // The 125 MHz clock.
  initial clock = 1'b0;
  always #4 clock = ~clock;

  // ********************
  // Shared tasks
  // ********************
  // Compares and tallies.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checked++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask

  // Prints the tallies and the verdict, then stops.
  task automatic conclude;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // A wait that ran out is a failure and ends the run.
  task automatic bound(input int n);
    begin
      if (n >= 64)
      begin
        n_fail++;
        conclude();
      end
    end
  endtask

  // Writes one register; each channel is released once taken.
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clock);
      awv <= 1'b1;
      awa <= a;
      wv  <= 1'b1;
      wd  <= d;
      brd <= 1'b1;
      do
      begin
        @(posedge clock);
        n++;
        if (awr)
          awv <= 1'b0;
        if (wrd)
          wv <= 1'b0;
      end
      while (!bv && n < 64);
      rsp = bresp;
      brd <= 1'b0;
      bound(n);
    end
  endtask

  // Reads one register, compares it and keeps the response.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    int n;
    begin
      n = 0;
      @(posedge clock);
      arv <= 1'b1;
      ara <= a;
      rrd <= 1'b1;
      do
      begin
        @(posedge clock);
        n++;
        if (ard)
          arv <= 1'b0;
      end
      while (!rv && n < 64);
      rsp = rresp;
      check(rdat, exp);
      rrd <= 1'b0;
      bound(n);
    end
  endtask

  // Sends a command and lets its effects settle.
  task automatic cmd(input logic [7:0] q[$]);
    begin
      host_u.send(q);
      @(negedge clock);
    end
  endtask

  // One-cycle end strobe from the playback engine.
  task automatic end_play;
    begin
      @(posedge clock);
      pdone <= 1'b1;
      @(posedge clock);
      pdone <= 1'b0;
      @(negedge clock);
    end
  endtask

  // ********************
  // Scenarios
  // ********************
  // Reset values and an unmapped read.
  task automatic s_reset;
    begin
      rchk(`PTCH_OFF_CFG, `PTCH_CFG_RST);
      rchk(`PTCH_OFF_STAT, 32'h0);
      check(rsp, `PTCH_RESP_OK);
      rchk(8'h18, 32'h0);
      check(rsp, `PTCH_RESP_ERR);
      wreg(8'h18, 32'h0);
      check(rsp, `PTCH_RESP_ERR);
      check({att, irq}, 2'b00);
    end
  endtask

  // Word play: no vocabulary, bad indices, then a play to its end.
  task automatic s_word;
    begin
      cmd('{`PTCH_OP_WORD, 8'h03});
      check(ps, 1'b0);
      rchk(`PTCH_OFF_STAT, 32'h4);
      wreg(`PTCH_OFF_CFG, 32'h000C_0A01);
      check(rsp, `PTCH_RESP_OK);
      cmd('{`PTCH_OP_WORD, 8'h0B});
      check(ps, 1'b0);
      rchk(`PTCH_OFF_STAT, 32'h6);
      wreg(`PTCH_OFF_CFG, 32'h0005_0A01);
      wreg(`PTCH_OFF_STAT, 32'h7);
      cmd('{`PTCH_OP_WORD, 8'h05});
      rchk(`PTCH_OFF_STAT, 32'h2);
      wreg(`PTCH_OFF_MASK, 32'h1);
      cmd('{`PTCH_OP_WORD, 8'h04});
      check({ps, psen, pidx, parg}, {2'b10, 8'h04, 16'h0});
      end_play();
      check({att, irq}, 2'b11);
      rchk(`PTCH_OFF_STAT, 32'h3);
      wreg(`PTCH_OFF_STAT, 32'h3);
      @(negedge clock);
      check({att, irq}, 2'b00);
    end
  endtask

  // Sentence: stopped once, then played to its end.
  task automatic s_sentence;
    begin
      cmd('{`PTCH_OP_SENT, 8'h00, 8'h03, 8'h06});
      check({ps, psen, pidx, parg}, {2'b11, 8'h00, 16'h0306});
      cmd('{`PTCH_OP_STOP});
      check(pstop, 1'b1);
      rchk(`PTCH_OFF_STATE, 32'h0);
      cmd('{`PTCH_OP_SENT, 8'h09, 8'hAB, 8'hCD});
      check({pidx, parg}, {8'h09, 16'hABCD});
      rchk(`PTCH_OFF_STATE, 32'h2);
      end_play();
      check(att, 1'b1);
      rchk(`PTCH_OFF_STAT, 32'h1);
      wreg(`PTCH_OFF_STAT, 32'h7);
    end
  endtask

  // Week clock: two good loads, then four bad words.
  task automatic s_week;
    logic [15:0] bad [4];
    begin
      bad = '{16'hDE08, 16'hDEC1, 16'hFC09, 16'h9E09};
      cmd('{`PTCH_OP_WEEK, 8'hDE, 8'h09});
      rchk(`PTCH_OFF_CLOCK, 32'hDE09);
      cmd('{`PTCH_OP_WEEK, 8'hFB, 8'hBF});
      rchk(`PTCH_OFF_CLOCK, 32'hFBBF);
      foreach (bad[i])
      begin
        cmd('{`PTCH_OP_WEEK, bad[i][15:8], bad[i][7:0]});
        rchk(`PTCH_OFF_CLOCK, 32'hFBBF);
        rchk(`PTCH_OFF_STAT, 32'h2);
        wreg(`PTCH_OFF_STAT, 32'h7);
      end
    end
  endtask

  // Label: refused with no message, then only clears bits.
  task automatic s_label;
    begin
      wreg(`PTCH_OFF_CFG, 32'h0005_0A00);
      wreg(`PTCH_OFF_TAG, 32'hF0FF);
      cmd('{`PTCH_OP_LABEL, 8'h00, 8'h00});
      cmd('{`PTCH_OP_SENT, 8'h00, 8'h00, 8'h00});
      check(ps, 1'b0);
      rchk(`PTCH_OFF_TAG, 32'hF0FF);
      rchk(`PTCH_OFF_STAT, 32'h4);
      wreg(`PTCH_OFF_CFG, 32'h0005_0A03);
      rchk(`PTCH_OFF_TAG, 32'hF0FF);
      cmd('{`PTCH_OP_LABEL, 8'hFF, 8'hF7});
      rchk(`PTCH_OFF_TAG, 32'hF0F7);
      cmd('{`PTCH_OP_LABEL, 8'h0F, 8'hFF});
      rchk(`PTCH_OFF_TAG, 32'h00F7);
    end
  endtask

  // Reset for ten cycles, then every scenario in turn.
  initial
  begin
    {rstn, awv, wv, brd, arv, rrd, pdone} = '0;
    {awa, ara, wd} = '0;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    s_reset();
    s_word();
    s_sentence();
    s_week();
    s_label();
    check(32'(host_u.bad), 32'h0);
    conclude();
  end
endmodule

`default_nettype wire

/* tb/ptch_host.sv */
`timescale 1ns/1ns
`default_nettype none

// Host byte source; it also checks the echo of every byte.
module ptch_host
(
  input  wire logic       clock,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data
);
  logic [7:0] last_r; // Byte sent at the last edge.
  logic       sent_r; // A byte went out at the last edge.
  int         bad;    // Wrong or missing echoes.

  // Idle link at time zero.
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    sent_r   = 1'b0;
    bad      = 0;
  end

  // Sends bytes back to back; the idle line then shows the inverse.
  task automatic send(input logic [7:0] q[$]);
    begin
      @(posedge clock);
      foreach (q[i])
      begin
        rx_valid <= 1'b1;
        rx_data  <= q[i];
        @(posedge clock);
      end
      rx_valid <= 1'b0;
      rx_data  <= ~q[q.size()-1];
    end
  endtask

  // Each byte must come back one cycle later, and nothing else.
  always @(posedge clock)
  begin
    sent_r <= rx_valid;
    last_r <= rx_data;
    if (tx_valid !== sent_r || (sent_r && tx_data !== last_r))
      bad++;
  end
endmodule

`default_nettype wire
